// File: bench/dss_rails.sv
// Behavioural rail model: pump feedback comparators seen by the sequencer
`timescale 1ns/1ps
module dss_rails (
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	input  wire logic i_neg_en,
	input  wire logic i_pos_en,
	input  wire logic i_slow,
	output wire logic o_neg_low,
	output wire logic o_pos_high
);
	// Rails climb while their pump runs and collapse once it stops
	integer n_q, p_q;
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			n_q <= 0;
			p_q <= 0;
		end else begin
			n_q <= i_neg_en ? n_q + 1 : 0;
			p_q <= i_pos_en ? p_q + 1 : 0;
		end
	end
	// Heavy load stretches the climb over several pump periods
	assign o_neg_low  = n_q > (i_slow ? 450 : 25);
	assign o_pos_high = p_q > (i_slow ? 450 : 25);
endmodule // dss_rails

// File: bench/dss_seq_properties.sv
// Port-level property checker for the display supply sequencer
`timescale 1ns/1ps
module dss_seq_properties (
	input logic       i_mclk, i_rst_n, i_power_down_n_input, i_main_below_target, i_pwm_trip,
	input logic       i_negative_pump_feedback_low, i_positive_pump_feedback_high,
	input logic       o_ref_en, o_ref_ground, o_main_en, o_ldo_en, o_soft_start, o_pwm_hold_low, o_switch_on,
	input logic       o_neg_pump_en, o_pos_pump_en, o_pos_low_side, o_pos_high_side, o_neg_low_side,
	input logic       o_neg_high_side, o_backplane_buffer_en, o_ready_n_oe, o_fault
);
	// One clock domain, so one default clock and disable
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	property p_off; !i_power_down_n_input |=> o_ref_ground && !o_ref_en ##1 !o_main_en && !o_ready_n_oe; endproperty
	a_off: assert property (p_off) else $error("stage left on in power down");
	property p_main; $rose(o_main_en) |-> o_ref_en && o_ldo_en && o_soft_start && o_pwm_hold_low; endproperty
	a_main: assert property (p_main) else $error("main start order wrong");
	property p_neg; $rose(o_neg_pump_en) |-> $past(i_pwm_trip, 2) && o_main_en; endproperty
	a_neg: assert property (p_neg) else $error("negative pump started early");
	property p_pos; $rose(o_pos_pump_en) |-> $past(i_negative_pump_feedback_low, 2); endproperty
	a_pos: assert property (p_pos) else $error("positive pump started early");
	property p_rdy; $rose(o_ready_n_oe) |-> o_backplane_buffer_en && $past(i_positive_pump_feedback_high, 2); endproperty
	a_rdy: assert property (p_rdy) else $error("ready raised early");
	property p_sw; o_switch_on && i_pwm_trip && !o_pwm_hold_low |=> !o_switch_on [*8]; endproperty
	a_sw: assert property (p_sw) else $error("switch not held off after trip");
	property p_set; $rose(o_switch_on) |-> $past(i_main_below_target); endproperty
	a_set: assert property (p_set) else $error("switch set with output high");
	// Both pumps share one half-cycle phase
	property p_pump; o_neg_pump_en && o_pos_pump_en && $past(o_pos_pump_en, 2) |-> o_pos_low_side != o_pos_high_side
		&& o_neg_high_side == o_pos_low_side && o_neg_low_side == o_pos_high_side; endproperty
	a_pump: assert property (p_pump) else $error("pump phase wrong");
	property p_half; o_pos_pump_en && $past(o_pos_pump_en, 2) && $changed(o_pos_low_side)
		|=> $stable(o_pos_low_side) [*8]; endproperty
	a_half: assert property (p_half) else $error("pump half too short");
	property p_flt; $rose(o_fault) |-> ##[0:2] (!o_ready_n_oe && o_ref_en && !o_main_en); endproperty
	a_flt: assert property (p_flt) else $error("fault did not shut outputs");
	property p_clr; $changed(i_power_down_n_input) |=> !o_fault; endproperty
	a_clr: assert property (p_clr) else $error("fault not cleared");
endmodule // dss_seq_properties

bind dss_sequencer dss_seq_properties u_dss_seq_properties (.*);

// File: bench/test_dss_sequencer.sv
// Self-checking bench for the display supply sequencer
`timescale 1ns/1ps
module test_dss_sequencer;
	logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_power_down_n_input = 1'b0, i_main_below_target = 1'b0;
	logic        i_pwm_trip = 1'b0, i_main_in_reg = 1'b0, i_fault_detect = 1'b0, slow = 1'b0, rq;
	wire         i_negative_pump_feedback_low, i_positive_pump_feedback_high, o_ref_en, o_ref_ground, o_main_en;
	wire         o_ldo_en, o_soft_start, o_pwm_hold_low, o_switch_on, o_neg_pump_en, o_pos_pump_en, o_pos_low_side;
	wire         o_pos_high_side, o_neg_low_side, o_neg_high_side, o_backplane_buffer_en, o_ready_n_oe, o_fault;
	wire [1:0]   o_ilim_step;
	integer      st, n_fail = 0, checked = 0, k;
	logic [31:0] rnd = 32'h95D6;
	logic [6:0]  ev;
	dss_sequencer u_dss_sequencer (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_power_down_n_input(i_power_down_n_input),
		.i_main_below_target(i_main_below_target), .i_pwm_trip(i_pwm_trip), .i_main_in_reg(i_main_in_reg),
		.i_negative_pump_feedback_low(i_negative_pump_feedback_low),
		.i_positive_pump_feedback_high(i_positive_pump_feedback_high), .i_fault_detect(i_fault_detect),
		.o_ref_en(o_ref_en), .o_ref_ground(o_ref_ground), .o_main_en(o_main_en), .o_ldo_en(o_ldo_en),
		.o_soft_start(o_soft_start), .o_ilim_step(o_ilim_step), .o_pwm_hold_low(o_pwm_hold_low),
		.o_switch_on(o_switch_on), .o_neg_pump_en(o_neg_pump_en), .o_pos_pump_en(o_pos_pump_en),
		.o_pos_low_side(o_pos_low_side), .o_pos_high_side(o_pos_high_side), .o_neg_low_side(o_neg_low_side),
		.o_neg_high_side(o_neg_high_side), .o_backplane_buffer_en(o_backplane_buffer_en),
		.o_ready_n_oe(o_ready_n_oe), .o_fault(o_fault));
	dss_rails u_dss_rails (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_neg_en(o_neg_pump_en), .i_pos_en(o_pos_pump_en),
		.i_slow(slow), .o_neg_low(i_negative_pump_feedback_low), .o_pos_high(i_positive_pump_feedback_high));
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	always #5 i_mclk = ~i_mclk;
	// Random load flags; the trip comparator echoes the switch one cycle late
	always @(posedge i_mclk) begin
		rnd <= lfsr(rnd);
		i_main_below_target <= rnd[3];
		i_main_in_reg <= rnd[7];
		i_pwm_trip <= o_switch_on;
	end
	// Sequence model: state steps on an edge, enables follow one edge later
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= 0;
			ev <= 7'h00;
			rq <= 1'b0;
		end else begin
			rq <= i_power_down_n_input;
			ev <= {st > 0 && st < 5, st > 0 && st < 5, st == 1, st > 1 && st < 5, st > 2 && st < 5, st == 4, st == 4};
			if (!i_power_down_n_input) st <= 0;
			else if (st == 0 || (st == 1 && i_pwm_trip) || (st == 2 && i_negative_pump_feedback_low)
				|| (st == 3 && i_positive_pump_feedback_high) || (st == 4 && i_fault_detect)) st <= st + 1;
		end
	end
	task automatic chk(input [7:0] g, input [7:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Bounded wait for the negative pump or for ready
	task automatic wt(input integer neg);
		for (k = 0; k < 3000 && (neg ? o_neg_pump_en : o_ready_n_oe) !== 1'b1; k++) @(posedge i_mclk);
		if ((neg ? o_neg_pump_en : o_ready_n_oe) !== 1'b1) begin
			n_fail++;
			wrap_up;
		end
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Enable vector compared with the model on every cycle
	always @(negedge i_mclk)
		if (i_rst_n) begin
			chk({o_main_en, o_ldo_en, o_pwm_hold_low, o_neg_pump_en, o_pos_pump_en, o_ready_n_oe,
				o_backplane_buffer_en, o_ref_en}, {ev, rq});
			chk({7'h00, o_ref_ground}, {7'h00, ~rq});
		end
	// Power-up, fault latch, clear, then a restart aborted mid-sequence
	initial begin
		repeat (8) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		repeat (5) @(posedge i_mclk);
		i_power_down_n_input <= 1'b1;
		wt(0);
		repeat (400) @(posedge i_mclk);
		// Random regulation flag has long since ended soft-start
		chk({6'h00, o_ilim_step}, 8'h03);
		chk({7'h00, o_soft_start}, 8'h00);
		i_fault_detect <= 1'b1;
		repeat (4) @(posedge i_mclk);
		i_fault_detect <= 1'b0;
		repeat (4) @(posedge i_mclk);
		#1 chk({7'h00, o_fault}, 8'h01);
		@(posedge i_mclk);
		i_power_down_n_input <= 1'b0;
		repeat (4) @(posedge i_mclk);
		#1 chk({7'h00, o_fault}, 8'h00);
		@(posedge i_mclk);
		slow <= 1'b1;
		i_power_down_n_input <= 1'b1;
		wt(1);
		i_power_down_n_input <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_power_down_n_input <= 1'b1;
		wt(0);
		repeat (200) @(posedge i_mclk);
		wrap_up;
	end
endmodule // test_dss_sequencer

// File: design/dss_sequencer.v
// Display supply sequencer: step-up switch control, pump drive and power-up order
`timescale 1ns/1ps
`include "dss_defs.vh"

module dss_sequencer #(
	parameter HAS_PUMPS      = 1,
	parameter SW_RATE_KHZ    = `DSS_SW_RATE_KHZ,
	parameter PUMP_PERIODS   = `DSS_PUMP_PERIODS,
	parameter SS_PHASE_US    = `DSS_SS_PHASE_US,
	parameter SS_MAX_PER     = `DSS_SS_MAX_PER
) (
	// Clock and reset
	input  wire       i_mclk,
	input  wire       i_rst_n,
	// Control input
	input  wire       i_power_down_n_input,
	// Analog comparator results
	input  wire       i_main_below_target,
	input  wire       i_pwm_trip,
	input  wire       i_main_in_reg,
	input  wire       i_negative_pump_feedback_low,
	input  wire       i_positive_pump_feedback_high,
	input  wire       i_fault_detect,
	// Enables and drives
	output reg        o_ref_en,
	output reg        o_ref_ground,
	output reg        o_main_en,
	output reg        o_ldo_en,
	output reg        o_soft_start,
	output reg  [1:0] o_ilim_step,
	output reg        o_pwm_hold_low,
	output reg        o_switch_on,
	output reg        o_neg_pump_en,
	output reg        o_pos_pump_en,
	output reg        o_pos_low_side,
	output reg        o_pos_high_side,
	output reg        o_neg_low_side,
	output reg        o_neg_high_side,
	output reg        o_backplane_buffer_en,
	output reg        o_ready_n_oe,
	output reg        o_fault
);

	// Oscillator period in system cycles
	localparam integer OSC_DIV  = (`DSS_CLK_KHZ / SW_RATE_KHZ);
	localparam integer SS_CYC   = (`DSS_CLK_KHZ / 1000) * SS_PHASE_US;
	localparam integer PUMP_DLY = 2 * PUMP_PERIODS;

	// ---------------------------------------------------------------
	// Oscillator divider
	// ---------------------------------------------------------------
	reg  [15:0] osc_cnt_q;
	wire        osc_tick = (osc_cnt_q == 16'h0000);
	reg         half_q;

	// One-cycle tick each oscillator period, pump phase toggles per tick
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			osc_cnt_q <= 16'h0000;
			half_q    <= 1'b0;
		end else begin
			if (osc_tick) begin
				osc_cnt_q <= OSC_DIV[15:0] - 16'h0001;
				half_q    <= ~half_q;
			end else begin
				osc_cnt_q <= osc_cnt_q - 16'h0001;
			end
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	reg  [2:0]  st_q;
	reg         pdn_prev_q;
	reg         pwm_prev_q;
	reg  [14:0] dly_q;
	reg  [17:0] ss_cnt_q;
	reg  [11:0] ss_per_q;

	// Power-down edge detect for fault clearing
	wire pdn_edge = (pdn_prev_q != i_power_down_n_input);

	// State advance; power-down forces idle so release restarts
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q       <= `DSS_ST_IDLE;
			pdn_prev_q <= 1'b0;
			pwm_prev_q <= 1'b0;
			dly_q      <= 15'h0000;
			o_fault    <= 1'b0;
		end else begin
			pdn_prev_q <= i_power_down_n_input;
			pwm_prev_q <= i_pwm_trip;
			if (pdn_edge)
				o_fault <= 1'b0;
			if (!i_power_down_n_input) begin
				st_q <= `DSS_ST_IDLE;
			end else begin
				case (st_q)
				`DSS_ST_IDLE: begin
					if (!o_fault) begin
						st_q       <= `DSS_ST_MAIN;
						pwm_prev_q <= 1'b0;
					end
				end
				`DSS_ST_MAIN: begin
					// Only the comparator matters, regulator state never checked
					if (i_pwm_trip != pwm_prev_q) begin
						st_q  <= `DSS_ST_NEG;
						dly_q <= 15'h0000;
					end
				end
				`DSS_ST_NEG: begin
					if (HAS_PUMPS != 0) begin
						if (i_negative_pump_feedback_low)
							st_q <= `DSS_ST_POS;
					end else if (osc_tick) begin
						if (dly_q == PUMP_DLY[14:0] - 15'h0001)
							st_q <= `DSS_ST_READY;
						else
							dly_q <= dly_q + 15'h0001;
					end
				end
				`DSS_ST_POS: begin
					if (i_positive_pump_feedback_high)
						st_q <= `DSS_ST_READY;
				end
				`DSS_ST_READY: begin
					if (i_fault_detect) begin
						st_q    <= `DSS_ST_FAULT;
						o_fault <= 1'b1;
					end
				end
				`DSS_ST_FAULT: begin
					// Held until power-down toggles
					if (!o_fault)
						st_q <= `DSS_ST_IDLE;
				end
				default: st_q <= `DSS_ST_IDLE;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Soft-start current limit steps
	// ---------------------------------------------------------------
	wire ss_active = (st_q != `DSS_ST_IDLE) && (st_q != `DSS_ST_FAULT) && (o_ilim_step != 2'h3);

	// Raise a quarter each phase without regulation; bounded by periods
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ilim_step <= 2'h0;
			ss_cnt_q    <= 18'h00000;
			ss_per_q    <= 12'h000;
		end else if (st_q == `DSS_ST_IDLE || st_q == `DSS_ST_FAULT) begin
			o_ilim_step <= 2'h0;
			ss_cnt_q    <= 18'h00000;
			ss_per_q    <= 12'h000;
		end else if (ss_active) begin
			if (i_main_in_reg || ss_per_q >= SS_MAX_PER[11:0] - 12'h001) begin
				o_ilim_step <= 2'h3;
			end else if (ss_cnt_q == SS_CYC[17:0] - 18'h00001) begin
				ss_cnt_q    <= 18'h00000;
				o_ilim_step <= o_ilim_step + 2'h1;
			end else begin
				ss_cnt_q <= ss_cnt_q + 18'h00001;
			end
			if (osc_tick)
				ss_per_q <= ss_per_q + 12'h001;
		end
	end

	// ---------------------------------------------------------------
	// Switch flip-flop and output enables
	// ---------------------------------------------------------------
	reg tripped_q;
	wire run = (st_q != `DSS_ST_IDLE) && (st_q != `DSS_ST_FAULT);

	// Set on tick when low, reset on trip, no retrigger in same period
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_switch_on <= 1'b0;
			tripped_q   <= 1'b0;
		end else if (!run) begin
			o_switch_on <= 1'b0;
			tripped_q   <= 1'b0;
		end else if (osc_tick) begin
			o_switch_on <= i_main_below_target;
			tripped_q   <= 1'b0;
		end else if (i_pwm_trip || tripped_q) begin
			o_switch_on <= 1'b0;
			tripped_q   <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Reference control
	// ---------------------------------------------------------------
	// Reference stays up through a fault, grounded only at power-down
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ref_en     <= 1'b0;
			o_ref_ground <= 1'b1;
		end else begin
			o_ref_en     <= i_power_down_n_input;
			o_ref_ground <= ~i_power_down_n_input;
		end
	end

	// ---------------------------------------------------------------
	// Main converter and linear regulator enables
	// ---------------------------------------------------------------
	// Regulator rides along with the main stage; its regulation gates nothing
	// Comparator held low in the main state only, until the first trip, so duty runs to its limits
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_main_en      <= 1'b0;
			o_ldo_en       <= 1'b0;
			o_soft_start   <= 1'b0;
			o_pwm_hold_low <= 1'b0;
		end else begin
			o_main_en      <= run;
			o_ldo_en       <= run;
			o_soft_start   <= run && (o_ilim_step != 2'h3);
			o_pwm_hold_low <= (st_q == `DSS_ST_MAIN);
		end
	end

	// ---------------------------------------------------------------
	// Charge pump enables
	// ---------------------------------------------------------------
	// A pumpless build keeps both enables low but still walks the delay
	wire pumps_fitted = (HAS_PUMPS != 0);

	// Negative pump first, positive pump once the negative rail is nearly up
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_neg_pump_en <= 1'b0;
			o_pos_pump_en <= 1'b0;
		end else begin
			o_neg_pump_en <= run && (st_q != `DSS_ST_MAIN) && pumps_fitted;
			o_pos_pump_en <= ((st_q == `DSS_ST_POS) || (st_q == `DSS_ST_READY)) && pumps_fitted;
		end
	end

	// ---------------------------------------------------------------
	// Charge pump phase drives
	// ---------------------------------------------------------------
	// Drives lag their enable by a cycle; the two sides of a pump never overlap
	// Positive pump charges on the low side first, negative on the high side
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pos_low_side  <= 1'b0;
			o_pos_high_side <= 1'b0;
			o_neg_low_side  <= 1'b0;
			o_neg_high_side <= 1'b0;
		end else begin
			o_pos_low_side  <= o_pos_pump_en && !half_q;
			o_pos_high_side <= o_pos_pump_en && half_q;
			o_neg_high_side <= o_neg_pump_en && !half_q;
			o_neg_low_side  <= o_neg_pump_en && half_q;
		end
	end

	// ---------------------------------------------------------------
	// Ready pin and backplane buffer
	// ---------------------------------------------------------------
	// Open-drain ready: enable high pulls the pin low, low leaves it floating
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_backplane_buffer_en <= 1'b0;
			o_ready_n_oe          <= 1'b0;
		end else begin
			o_backplane_buffer_en <= (st_q == `DSS_ST_READY);
			o_ready_n_oe          <= (st_q == `DSS_ST_READY);
		end
	end

endmodule // dss_sequencer

// File: inc/dss_defs.vh
// Constants for the display supply sequencer
`ifndef DSS_DEFS_VH
`define DSS_DEFS_VH

// Sequencer states
`define DSS_ST_IDLE      3'h0
`define DSS_ST_MAIN      3'h1
`define DSS_ST_NEG       3'h2
`define DSS_ST_POS       3'h3
`define DSS_ST_READY     3'h4
`define DSS_ST_FAULT     3'h5

// Switching clock rate in kHz (500 or 1000 by variant)
`define DSS_SW_RATE_KHZ  1000
// System clock rate in kHz
`define DSS_CLK_KHZ      100000
// Pump startup delay in switching periods, per pump
`define DSS_PUMP_PERIODS 4096
// Soft-start phase time in microseconds
`define DSS_SS_PHASE_US  1000
// Soft-start full limit bound in switching periods
`define DSS_SS_MAX_PER   3072

`endif
